// >>> mabx_consts.svh
`ifndef MABX_CONSTS_SVH
`define MABX_CONSTS_SVH

// Status flag positions
`define MABX_FLAG_C 0
`define MABX_FLAG_Z 1
`define MABX_FLAG_N 2
`define MABX_FLAG_V 3
`define MABX_FLAG_S 4
`define MABX_FLAG_H 5
`define MABX_FLAG_T 6
`define MABX_FLAG_I 7

// Register byte offsets
`define MABX_OFS_STATUS 8'h00
`define MABX_OFS_EXTENDED_INDIRECT_REGISTER   8'h04
`define MABX_OFS_STATE  8'h08

// Reset values
`define MABX_STATUS_RST 8'h00
`define MABX_EXTENDED_INDIRECT_REGISTER_RST   6'h00

// Cycle counts
`define MABX_CYC_ONE   3'h1
`define MABX_CYC_TWO   3'h2
`define MABX_CYC_THREE 3'h3

// Bus responses
`define MABX_RESP_OKAY   2'h0
`define MABX_RESP_SLVERR 2'h2

`endif

// >>> mabx_pkg.sv
package mabx_pkg;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_WITH_BORROW,
    OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE,
    OP_CONJUNCTION, OP_DISJUNCTION, OP_EXCLUSIVE_DISJUNCTION,
    OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_TEST,
    OP_MULTIPLY_UU, OP_MULTIPLY_SS, OP_MULTIPLY_SU,
    OP_FRAC_MULTIPLY_UU, OP_FRAC_MULTIPLY_SS, OP_FRAC_MULTIPLY_SU,
    OP_RELATIVE_JUMP, OP_RELATIVE_CALL, OP_POINTER_JUMP,
    OP_EXTENDED_POINTER_JUMP, OP_POINTER_CALL,
    OP_EXTENDED_POINTER_CALL, OP_COMPARE_REGS,
    OP_COMPARE_REGS_BORROW, OP_COMPARE_SKIP_EQUAL,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_UNSIGNED_GE, OP_BRANCH_UNSIGNED_LT,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED
  } mabx_op_t;

  typedef struct packed {
    logic        valid;
    mabx_op_t    op;
    logic [7:0]  opA;
    logic [7:0]  opB;
    logic [15:0] pairVal;
    logic [2:0]  bitSel;
    logic        ioBit;
    logic [11:0] offset;
    logic [15:0] zPtr;
    logic [21:0] curPc;
    logic        nextTwoWord;
  } mabx_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] resData;
    logic        wrByte;
    logic        wrPair;
    logic        wrProduct;
    logic        pcLoad;
    logic [21:0] newPc;
    logic        pushRet;
    logic [21:0] retPc;
  } mabx_res_t;

  typedef struct packed {
    logic [15:0] res;
    logic [7:0]  flags;
  } mabx_alu_t;

  typedef struct packed {
    logic [2:0]  cnt;
    logic        busy;
    mabx_res_t   res;
    logic [7:0]  flags;
    logic [5:0]  extended_indirect_register;
    logic        awHeld;
    logic [7:0]  awAddr;
    logic        wHeld;
    logic [7:0]  wData;
    logic        wStrb0;
    logic        awRdy;
    logic        wRdy;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } mabx_state_t;

endpackage

// >>> mabx_core.sv
`timescale 1ns/1ps
`include "mabx_consts.svh"

module mabx_core #(
  parameter bit PcBytes3 = 1'b1
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire mabx_pkg::mabx_req_t req,
  output mabx_pkg::mabx_res_t     res,
  output logic                    execBusy,
  output logic [7:0]              statusRegister,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  mabx_pkg::mabx_state_t st_q;
  mabx_pkg::mabx_state_t st_d;
  logic                  accept;

  assign accept = req.valid && !st_q.busy;

  function automatic mabx_pkg::mabx_alu_t f_arith(
    input logic [7:0] a, input logic [7:0] b, input logic cin,
    input logic sub, input logic chainZ, input logic [7:0] fin);
    logic [8:0] r9;
    logic [7:0] r;
    logic       h;
    logic       v;
    mabx_pkg::mabx_alu_t o;
    r9 = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin})
             : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    r = r9[7:0];
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
    end
    o.res = {8'h00, r};
    o.flags = fin;
    o.flags[`MABX_FLAG_C] = r9[8];
    // Borrow-chained forms only keep Z if earlier bytes were zero
    o.flags[`MABX_FLAG_Z] = (r == 8'h00) &
                            (~chainZ | fin[`MABX_FLAG_Z]);
    o.flags[`MABX_FLAG_N] = r[7];
    o.flags[`MABX_FLAG_V] = v;
    o.flags[`MABX_FLAG_S] = r[7] ^ v;
    o.flags[`MABX_FLAG_H] = h;
    return o;
  endfunction

  function automatic mabx_pkg::mabx_alu_t f_logic(
    input logic [7:0] r, input logic [7:0] fin);
    mabx_pkg::mabx_alu_t o;
    o.res = {8'h00, r};
    o.flags = fin;
    o.flags[`MABX_FLAG_Z] = (r == 8'h00);
    o.flags[`MABX_FLAG_N] = r[7];
    o.flags[`MABX_FLAG_V] = 1'b0;
    o.flags[`MABX_FLAG_S] = r[7];
    return o;
  endfunction

  function automatic mabx_pkg::mabx_alu_t f_word(
    input logic [15:0] p, input logic [7:0] k, input logic sub,
    input logic [7:0] fin);
    logic [15:0] r;
    logic        v;
    mabx_pkg::mabx_alu_t o;
    r = sub ? (p - {8'h00, k}) : (p + {8'h00, k});
    v = sub ? (p[15] & ~r[15]) : (~p[15] & r[15]);
    o.res = r;
    o.flags = fin;
    o.flags[`MABX_FLAG_C] = sub ? (r[15] & ~p[15]) : (~r[15] & p[15]);
    o.flags[`MABX_FLAG_Z] = (r == 16'h0000);
    o.flags[`MABX_FLAG_N] = r[15];
    o.flags[`MABX_FLAG_V] = v;
    o.flags[`MABX_FLAG_S] = r[15] ^ v;
    return o;
  endfunction

  function automatic mabx_pkg::mabx_alu_t f_mul(
    input logic [7:0] a, input logic [7:0] b, input logic sa,
    input logic sb, input logic frac, input logic [7:0] fin);
    logic signed [17:0] p;
    logic [15:0]        r;
    mabx_pkg::mabx_alu_t o;
    p = $signed({sa & a[7], a}) * $signed({sb & b[7], b});
    r = p[15:0];
    o.flags = fin;
    // Carry is product bit 15 before the fractional shift
    o.flags[`MABX_FLAG_C] = r[15];
    if (frac) begin
      r = {r[14:0], 1'b0};
    end
    o.flags[`MABX_FLAG_Z] = (r == 16'h0000);
    o.res = r;
    return o;
  endfunction

  function automatic logic [21:0] f_rel(
    input logic [21:0] pc, input logic [11:0] k);
    return pc + {{10{k[11]}}, k} + 22'h000001;
  endfunction

  always_comb begin
    mabx_pkg::mabx_alu_t alu;
    logic [2:0]          cyc;
    logic                cond;
    logic                isSkip;
    logic                isBranch;
    logic                ioSkip;
    logic [7:0]          f;
    alu = '0;
    cyc = `MABX_CYC_ONE;
    cond = 1'b0;
    isSkip = 1'b0;
    isBranch = 1'b0;
    ioSkip = 1'b0;
    f = st_q.flags;
    st_d = st_q;
    st_d.res.done = 1'b0;

    // Register bus, write side
    if (st_q.awRdy && s_axi_awvalid) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = s_axi_awaddr;
    end
    if (st_q.wRdy && s_axi_wvalid) begin
      st_d.wHeld = 1'b1;
      st_d.wData = s_axi_wdata[7:0];
      st_d.wStrb0 = s_axi_wstrb[0];
    end
    if (st_q.bValid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end
    if (st_q.awHeld && st_q.wHeld && !st_q.bValid) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = `MABX_RESP_OKAY;
      case (st_q.awAddr)
        `MABX_OFS_STATUS: begin
          if (st_q.wStrb0) begin
            st_d.flags = st_q.wData;
          end
        end
        `MABX_OFS_EXTENDED_INDIRECT_REGISTER: begin
          if (st_q.wStrb0) begin
            st_d.extended_indirect_register = st_q.wData[5:0];
          end
        end
        `MABX_OFS_STATE: begin
        end
        default: begin
          st_d.bResp = `MABX_RESP_SLVERR;
        end
      endcase
    end
    st_d.awRdy = !st_d.awHeld && !st_d.bValid;
    st_d.wRdy = !st_d.wHeld && !st_d.bValid;

    // Register bus, read side
    if (st_q.rValid && s_axi_rready) begin
      st_d.rValid = 1'b0;
      st_d.arRdy = 1'b1;
    end
    if (st_q.arRdy && s_axi_arvalid) begin
      st_d.arRdy = 1'b0;
      st_d.rValid = 1'b1;
      st_d.rResp = `MABX_RESP_OKAY;
      case (s_axi_araddr)
        `MABX_OFS_STATUS: st_d.rData = {24'h000000, st_q.flags};
        `MABX_OFS_EXTENDED_INDIRECT_REGISTER:   st_d.rData = {26'h0000000, st_q.extended_indirect_register};
        `MABX_OFS_STATE: begin
          st_d.rData = {st_q.busy, 9'h000, st_q.res.newPc};
        end
        default: begin
          st_d.rData = 32'h00000000;
          st_d.rResp = `MABX_RESP_SLVERR;
        end
      endcase
    end

    // Execution; an accepted operation overrides a bus write to flags
    if (st_q.busy) begin
      st_d.cnt = st_q.cnt - 3'h1;
      if (st_q.cnt == 3'h1) begin
        st_d.res.done = 1'b1;
        st_d.busy = 1'b0;
      end
    end else if (req.valid) begin
      st_d.res.wrByte = 1'b0;
      st_d.res.wrPair = 1'b0;
      st_d.res.wrProduct = 1'b0;
      st_d.res.pcLoad = 1'b0;
      st_d.res.pushRet = 1'b0;
      st_d.res.newPc = req.curPc + 22'h000001;
      st_d.res.retPc = req.curPc + 22'h000001;
      case (req.op)
        mabx_pkg::OP_ADD, mabx_pkg::OP_ADD_CARRY: begin
          alu = f_arith(req.opA, req.opB, f[`MABX_FLAG_C] &
                (req.op == mabx_pkg::OP_ADD_CARRY), 1'b0, 1'b0, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_SUB, mabx_pkg::OP_SUB_WITH_BORROW: begin
          cond = (req.op == mabx_pkg::OP_SUB_WITH_BORROW);
          alu = f_arith(req.opA, req.opB, f[`MABX_FLAG_C] & cond,
                        1'b1, cond, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_COMPARE_REGS,
        mabx_pkg::OP_COMPARE_REGS_BORROW: begin
          cond = (req.op == mabx_pkg::OP_COMPARE_REGS_BORROW);
          // Difference only feeds the flags
          alu = f_arith(req.opA, req.opB, f[`MABX_FLAG_C] & cond,
                        1'b1, cond, f);
        end
        mabx_pkg::OP_WORD_ADD_IMMEDIATE,
        mabx_pkg::OP_WORD_SUB_IMMEDIATE: begin
          alu = f_word(req.pairVal, req.opB,
                req.op == mabx_pkg::OP_WORD_SUB_IMMEDIATE, f);
          st_d.res.wrPair = 1'b1;
          cyc = `MABX_CYC_TWO;
        end
        mabx_pkg::OP_CONJUNCTION: begin
          alu = f_logic(req.opA & req.opB, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_DISJUNCTION: begin
          alu = f_logic(req.opA | req.opB, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_EXCLUSIVE_DISJUNCTION: begin
          alu = f_logic(req.opA ^ req.opB, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_SET_MASK_BITS: begin
          alu = f_logic(req.opA | req.opB, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_CLEAR_MASK_BITS: begin
          alu = f_logic(req.opA & ~req.opB, f);
          st_d.res.wrByte = 1'b1;
        end
        mabx_pkg::OP_ZERO_MINUS_TEST: begin
          alu = f_logic(req.opA & req.opA, f);
        end
        mabx_pkg::OP_MULTIPLY_UU, mabx_pkg::OP_MULTIPLY_SS,
        mabx_pkg::OP_MULTIPLY_SU, mabx_pkg::OP_FRAC_MULTIPLY_UU,
        mabx_pkg::OP_FRAC_MULTIPLY_SS,
        mabx_pkg::OP_FRAC_MULTIPLY_SU: begin
          alu = f_mul(req.opA, req.opB,
            req.op inside {mabx_pkg::OP_MULTIPLY_SS,
                           mabx_pkg::OP_MULTIPLY_SU,
                           mabx_pkg::OP_FRAC_MULTIPLY_SS,
                           mabx_pkg::OP_FRAC_MULTIPLY_SU},
            req.op inside {mabx_pkg::OP_MULTIPLY_SS,
                           mabx_pkg::OP_FRAC_MULTIPLY_SS},
            req.op inside {mabx_pkg::OP_FRAC_MULTIPLY_UU,
                           mabx_pkg::OP_FRAC_MULTIPLY_SS,
                           mabx_pkg::OP_FRAC_MULTIPLY_SU},
            f);
          st_d.res.wrProduct = 1'b1;
          cyc = `MABX_CYC_TWO;
        end
        mabx_pkg::OP_RELATIVE_JUMP, mabx_pkg::OP_RELATIVE_CALL: begin
          st_d.res.pcLoad = 1'b1;
          st_d.res.newPc = f_rel(req.curPc, req.offset);
          cyc = `MABX_CYC_TWO;
          if (req.op == mabx_pkg::OP_RELATIVE_CALL) begin
            st_d.res.pushRet = 1'b1;
            // Wide program counter needs a third return byte
            cyc = PcBytes3 ? `MABX_CYC_THREE : `MABX_CYC_TWO;
          end
        end
        mabx_pkg::OP_POINTER_JUMP, mabx_pkg::OP_POINTER_CALL: begin
          st_d.res.pcLoad = 1'b1;
          st_d.res.newPc = {6'h00, req.zPtr};
          cyc = `MABX_CYC_TWO;
          if (req.op == mabx_pkg::OP_POINTER_CALL) begin
            st_d.res.pushRet = 1'b1;
            cyc = PcBytes3 ? `MABX_CYC_THREE : `MABX_CYC_TWO;
          end
        end
        mabx_pkg::OP_EXTENDED_POINTER_JUMP: begin
          st_d.res.pcLoad = 1'b1;
          st_d.res.newPc = {st_q.extended_indirect_register, req.zPtr};
          cyc = `MABX_CYC_TWO;
        end
        mabx_pkg::OP_EXTENDED_POINTER_CALL: begin
          st_d.res.pcLoad = 1'b1;
          st_d.res.pushRet = 1'b1;
          st_d.res.newPc = {st_q.extended_indirect_register, req.zPtr};
          cyc = `MABX_CYC_THREE;
        end
        mabx_pkg::OP_COMPARE_SKIP_EQUAL: begin
          isSkip = 1'b1;
          cond = (req.opA == req.opB);
        end
        mabx_pkg::OP_SKIP_REG_BIT_CLEAR: begin
          isSkip = 1'b1;
          cond = !req.opA[req.bitSel];
        end
        mabx_pkg::OP_SKIP_REG_BIT_SET: begin
          isSkip = 1'b1;
          cond = req.opA[req.bitSel];
        end
        mabx_pkg::OP_SKIP_IO_BIT_CLEAR: begin
          isSkip = 1'b1;
          ioSkip = 1'b1;
          cond = !req.ioBit;
        end
        mabx_pkg::OP_SKIP_IO_BIT_SET: begin
          isSkip = 1'b1;
          ioSkip = 1'b1;
          cond = req.ioBit;
        end
        mabx_pkg::OP_BRANCH_FLAG_SET: begin
          isBranch = 1'b1;
          cond = f[req.bitSel];
        end
        mabx_pkg::OP_BRANCH_FLAG_CLEAR: begin
          isBranch = 1'b1;
          cond = !f[req.bitSel];
        end
        mabx_pkg::OP_BRANCH_SIGNED_GE: begin
          isBranch = 1'b1;
          cond = !(f[`MABX_FLAG_N] ^ f[`MABX_FLAG_V]);
        end
        mabx_pkg::OP_BRANCH_SIGNED_LT: begin
          isBranch = 1'b1;
          cond = f[`MABX_FLAG_N] ^ f[`MABX_FLAG_V];
        end
        mabx_pkg::OP_BRANCH_UNSIGNED_GE: begin
          isBranch = 1'b1;
          cond = !f[`MABX_FLAG_C];
        end
        mabx_pkg::OP_BRANCH_UNSIGNED_LT: begin
          isBranch = 1'b1;
          cond = f[`MABX_FLAG_C];
        end
        mabx_pkg::OP_BRANCH_IRQ_ENABLED: begin
          isBranch = 1'b1;
          cond = f[`MABX_FLAG_I];
        end
        mabx_pkg::OP_BRANCH_IRQ_DISABLED: begin
          isBranch = 1'b1;
          cond = !f[`MABX_FLAG_I];
        end
        default: begin
          // Unknown codes must not clear the flags
          alu.flags = f;
        end
      endcase
      if (isSkip || isBranch || st_d.res.pcLoad) begin
        alu.flags = f;
      end
      st_d.res.resData = alu.res;
      st_d.flags = alu.flags;
      if (isSkip) begin
        cyc = `MABX_CYC_ONE + {2'b00, ioSkip} + {2'b00, cond} +
              {2'b00, cond & req.nextTwoWord};
        st_d.res.pcLoad = cond;
        st_d.res.newPc = req.curPc + (req.nextTwoWord ?
                         22'h000003 : 22'h000002);
      end
      if (isBranch) begin
        cyc = cond ? `MABX_CYC_TWO : `MABX_CYC_ONE;
        st_d.res.pcLoad = cond;
        st_d.res.newPc = f_rel(req.curPc, req.offset);
      end
      st_d.cnt = cyc - 3'h1;
      if (cyc == `MABX_CYC_ONE) begin
        st_d.res.done = 1'b1;
      end else begin
        st_d.busy = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.flags <= `MABX_STATUS_RST;
      st_q.extended_indirect_register <= `MABX_EXTENDED_INDIRECT_REGISTER_RST;
      st_q.awRdy <= 1'b1;
      st_q.wRdy <= 1'b1;
      st_q.arRdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign res = st_q.res;
  assign execBusy = st_q.busy;
  assign statusRegister = st_q.flags;
  assign s_axi_awready = st_q.awRdy;
  assign s_axi_wready = st_q.wRdy;
  assign s_axi_bvalid = st_q.bValid;
  assign s_axi_bresp = st_q.bResp;
  assign s_axi_arready = st_q.arRdy;
  assign s_axi_rvalid = st_q.rValid;
  assign s_axi_rdata = st_q.rData;
  assign s_axi_rresp = st_q.rResp;

  a_add_result: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_ADD |=>
    res.done && res.wrByte && res.resData[7:0] == $past(req.opA + req.opB))
    else $error("byte add result wrong");

  a_word_timing: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_WORD_ADD_IMMEDIATE |=>
    !res.done ##1 res.done) else $error("word add not two cycles");

  a_word_sub: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_WORD_SUB_IMMEDIATE |=>
    res.wrPair && res.resData == $past(req.pairVal - {8'h00, req.opB}))
    else $error("word subtract result wrong");

  a_logic_carry: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_EXCLUSIVE_DISJUNCTION |=>
    statusRegister[`MABX_FLAG_C] == $past(statusRegister[`MABX_FLAG_C]) &&
    !statusRegister[`MABX_FLAG_V]) else $error("logic touched carry");

  a_clear_mask: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_CLEAR_MASK_BITS |=>
    res.resData[7:0] == $past(req.opA & ~req.opB))
    else $error("clear mask wrong");

  a_test_zero: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_ZERO_MINUS_TEST |=> !res.wrByte &&
    statusRegister[`MABX_FLAG_Z] == ($past(req.opA) == 8'h00))
    else $error("test flags wrong");

  a_mul_timing: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_MULTIPLY_UU |=> !res.done ##1
    res.done && res.resData == $past(req.opA, 2) * $past(req.opB, 2))
    else $error("unsigned multiply wrong");

  a_frac_shift: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_FRAC_MULTIPLY_UU |=> !res.resData[0])
    else $error("fractional product not shifted");

  a_ptr_jump: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_POINTER_JUMP |=>
    res.newPc == {6'h00, $past(req.zPtr)}) else $error("pointer jump pc");

  a_ext_call: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_EXTENDED_POINTER_CALL |=>
    !res.done [*2] ##1 res.done) else $error("extended call not 3 cycles");

  a_branch_skip: assert property (@(posedge clk) disable iff (rst)
    accept && req.op == mabx_pkg::OP_BRANCH_UNSIGNED_LT &&
    !statusRegister[`MABX_FLAG_C] |=> res.done && !res.pcLoad)
    else $error("untaken branch wrong");

endmodule // mabx_core

// >>> mabx_regfile_model.sv
`timescale 1ns/1ps
module mabx_regfile_model (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire mabx_pkg::mabx_res_t res,
  output logic [15:0]              prodPair
);
  // R1:R0 latches only on the completion pulse, as the register file would
  always_ff @(posedge clk or posedge rst) begin
    if (rst) prodPair <= 16'h0000;
    else if (res.done && res.wrProduct) prodPair <= res.resData;
  end
endmodule // mabx_regfile_model

// >>> tb_mcu_alu_branch_exec.sv
`timescale 1ns/1ps
module tb_mcu_alu_branch_exec;
  logic                clk, rst, busy, awv, wv, bv, bRdy, arv, rv, rRdy;
  logic                awr, wr, arr, two, iob;
  logic [2:0]          bs;
  logic [7:0]          sr, awa, ara, a, b;
  logic [31:0]         wd, rd, q, r32;
  logic [1:0]          bresp, rresp, rsp;
  logic [15:0]         pv, zp, prod, mp;
  logic signed [15:0]  sp;
  logic [11:0]         off;
  logic [21:0]         pc;
  logic [13:0]         e;
  integer              seed, bad_count, total_checks, i;
  mabx_pkg::mabx_req_t req;
  mabx_pkg::mabx_res_t res;
  mabx_core i_mabx_core (.clk(clk), .rst(rst), .req(req), .res(res),
    .execBusy(busy), .statusRegister(sr), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rRdy));
  mabx_regfile_model i_mabx_regfile_model (.clk(clk), .rst(rst),
    .res(res), .prodPair(prod));
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Flags {res, H, S, V, N, Z, C} of a byte add or subtract
  function automatic logic [13:0] alu(input logic [7:0] x, y, input logic s);
    logic [8:0] r;
    logic [4:0] h;
    logic       v;
    r = s ? {1'h0, x} - y : {1'h0, x} + y;
    h = s ? {1'h0, x[3:0]} - y[3:0] : {1'h0, x[3:0]} + y[3:0];
    v = (s ? x[7] ^ y[7] : ~(x[7] ^ y[7])) & (x[7] ^ r[7]);
    return {r[7:0], h[4], v ^ r[7], v, r[7], r[7:0] == 8'h00, r[8]};
  endfunction
  // Relative target, wrapped to the program-counter width
  function automatic logic [21:0] tgt(input logic [21:0] p,
                                      input logic [11:0] k);
    return p + {{10{k[11]}}, k} + 22'h000001;
  endfunction
  // Both directions share one task; only one transfer is ever open
  task automatic axi(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    logic   hA, hW, hB;
    integer c;
    @(posedge clk);
    awa <= ad; ara <= ad; wd <= d; awv <= w; wv <= w; bRdy <= w;
    arv <= !w; rRdy <= !w;
    c = 0; hB = 0;
    while (!hB && c < 50) begin
      #1;
      hA = (awv && awr) || (arv && arr);
      hW = wv && wr;
      hB = (bv && bRdy) || (rv && rRdy);
      q = rd; rsp = w ? bresp : rresp;
      @(posedge clk);
      if (hA) begin awv <= 1'h0; arv <= 1'h0; end
      if (hW) wv <= 1'h0;
      if (hB) begin bRdy <= 1'h0; rRdy <= 1'h0; end
      c++;
    end
    if (!hB) bad_count++;
  endtask
  task automatic ex(input mabx_pkg::mabx_op_t o, input logic [7:0] x, y,
                    input integer n);
    integer c;
    @(posedge clk);
    req <= {1'h1, o, x, y, pv, bs, iob, off, zp, pc, two};
    @(posedge clk);
    req.valid <= 1'h0;
    #1;
    chk(busy, n > 1);
    c = 1;
    while (res.done !== 1'h1 && c < 20) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk(c, n);
  endtask
  task automatic br(input logic [7:0] s, input mabx_pkg::mabx_op_t o,
                    input logic t);
    axi(1'h1, 8'h00, {24'h0, s});
    ex(o, 8'h00, 8'h00, t ? 2 : 1);
    chk(res.pcLoad, t);
    chk(res.newPc, tgt(pc, off));
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    bad_count++;
    test_done;
  end
  initial begin
    seed = 87; bad_count = 0; total_checks = 0; rst = 1'h1; req = '0;
    {awv, wv, bRdy, arv, rRdy, two, iob, bs} = 10'h000;
    awa = 8'h00; ara = 8'h00;
    wd = 32'h0; pv = 16'h0; zp = 16'h1234; off = 12'hFFE; pc = 22'h000100;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    axi(1'h0, 8'h00, 32'h0);
    chk(q, 32'h0);
    axi(1'h0, 8'h10, 32'h0);
    chk(rsp, 2'h2);
    for (i = 0; i < 24; i++) begin
      r32 = $random(seed);
      {a, b} = r32[15:0];
      if (i < 2) {a, b} = i ? 16'h0001 : 16'h7F01;
      e = alu(a, b, i[0]);
      ex(i[0] ? mabx_pkg::OP_SUB : mabx_pkg::OP_ADD, a, b, 1);
      chk(res.resData[7:0], e[13:6]);
      chk(sr[5:0], e[5:0]);
      e = alu(b, a, 1'h1);
      ex(mabx_pkg::OP_COMPARE_REGS, b, a, 1);
      chk(sr[5:0], e[5:0]);
      chk(res.wrByte, 1'h0);
      ex(mabx_pkg::OP_CONJUNCTION, a, b, 1);
      chk({res.resData[7:0], sr[0], sr[3]}, {a & b, e[0], 1'h0});
      ex(mabx_pkg::OP_ADD_CARRY, a, b, 1);
      chk(res.resData[7:0], {a + b + {7'h00, e[0]}});
      ex(mabx_pkg::OP_EXCLUSIVE_DISJUNCTION, a, b, 1);
      chk({res.resData[7:0], sr[2]}, {a ^ b, a[7] ^ b[7]});
      ex(mabx_pkg::OP_SET_MASK_BITS, a, b, 1);
      chk(res.resData[7:0], a | b);
      ex(mabx_pkg::OP_CLEAR_MASK_BITS, a, b, 1);
      chk(res.resData[7:0], a & ~b);
      ex(mabx_pkg::OP_ZERO_MINUS_TEST, a, b, 1);
      chk({res.wrByte, sr[1]}, {1'h0, a == 8'h00});
      mp = a * b;
      ex(mabx_pkg::OP_MULTIPLY_UU, a, b, 2);
      // Register file takes the product on the edge after done
      @(posedge clk);
      #1;
      chk({prod, sr[1:0]}, {mp, mp == 16'h0, mp[15]});
      ex(mabx_pkg::OP_FRAC_MULTIPLY_UU, a, b, 2);
      chk({res.resData, sr[0]}, {mp[14:0], 1'h0, mp[15]});
      mp = $signed(a) * $signed({1'h0, b});
      ex(mabx_pkg::OP_MULTIPLY_SU, a, b, 2);
      chk(res.resData, mp);
      sp = $signed(a) * $signed(b);
      ex(mabx_pkg::OP_FRAC_MULTIPLY_SS, a, b, 2);
      chk({res.resData, sr[0]}, {sp[14:0], 1'h0, sp[15]});
    end
    pv = 16'hFFFF;
    ex(mabx_pkg::OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h01, 2);
    chk({res.resData, sr[4:0], res.wrPair}, {16'h0, 5'h03, 1'h1});
    pv = 16'h0000;
    ex(mabx_pkg::OP_WORD_SUB_IMMEDIATE, 8'h00, 8'h3F, 2);
    chk({res.resData, sr[4:0]}, {16'hFFC1, 5'h15});
    ex(mabx_pkg::OP_RELATIVE_JUMP, 8'h00, 8'h00, 2);
    chk(res.newPc, 22'h0000FF);
    axi(1'h1, 8'h04, 32'h2A);
    ex(mabx_pkg::OP_EXTENDED_POINTER_JUMP, 8'h00, 8'h00, 2);
    chk(res.newPc, {6'h2A, zp});
    ex(mabx_pkg::OP_POINTER_JUMP, 8'h00, 8'h00, 2);
    chk(res.newPc, {6'h00, zp});
    ex(mabx_pkg::OP_EXTENDED_POINTER_CALL, 8'h00, 8'h00, 3);
    chk({res.pushRet, res.retPc}, {1'h1, pc + 22'h1});
    axi(1'h0, 8'h04, 32'h0);
    chk(q, 32'h2A);
    two = 1'h1;
    ex(mabx_pkg::OP_COMPARE_SKIP_EQUAL, 8'h55, 8'h55, 3);
    chk(res.newPc, pc + 22'h3);
    two = 1'h0;
    bs = 3'h7;
    iob = 1'h1;
    ex(mabx_pkg::OP_SKIP_REG_BIT_SET, 8'h80, 8'h00, 2);
    chk({res.pcLoad, res.newPc}, {1'h1, pc + 22'h2});
    ex(mabx_pkg::OP_SKIP_REG_BIT_CLEAR, 8'h80, 8'h00, 1);
    chk(res.pcLoad, 1'h0);
    ex(mabx_pkg::OP_SKIP_IO_BIT_SET, 8'h00, 8'h00, 3);
    ex(mabx_pkg::OP_SKIP_IO_BIT_CLEAR, 8'h00, 8'h00, 2);
    ex(mabx_pkg::OP_RELATIVE_CALL, 8'h00, 8'h00, 3);
    chk({res.pushRet, res.newPc}, {1'h1, 22'h0000FF});
    ex(mabx_pkg::OP_POINTER_CALL, 8'h00, 8'h00, 3);
    chk({res.pushRet, res.newPc}, {1'h1, 6'h00, zp});
    br(8'h04, mabx_pkg::OP_BRANCH_SIGNED_LT, 1'h1);
    br(8'h0C, mabx_pkg::OP_BRANCH_SIGNED_GE, 1'h1);
    br(8'h01, mabx_pkg::OP_BRANCH_UNSIGNED_GE, 1'h0);
    br(8'h80, mabx_pkg::OP_BRANCH_IRQ_ENABLED, 1'h1);
    br(8'h00, mabx_pkg::OP_BRANCH_IRQ_DISABLED, 1'h1);
    br(8'h00, mabx_pkg::OP_BRANCH_UNSIGNED_LT, 1'h0);
    br(8'h80, mabx_pkg::OP_BRANCH_FLAG_SET, 1'h1);
    br(8'h80, mabx_pkg::OP_BRANCH_FLAG_CLEAR, 1'h0);
    test_done;
  end
endmodule // tb_mcu_alu_branch_exec
